// ==== hsd_defs.vh ====
// constants for the speed and direction sensor core
// Notes on behaviour
// R1: first pulse on rising slope, second next rise
// R2: uncalibrated threshold twice limit, tracks amplitude
// R3: offset updates after two extrema, edge-matched
// R4: offset update independent of output switching
// R5: offset fed back through correction dac
// R6: successful correction enters calibrated hysteresis switching
// R7: calibrated threshold half amplitude, floor twice limit
// R8: small signals: two pulses, fourth calibrated
// R9: hysteresis one eighth amplitude, floor limit
// R10: no switching below adaptive hysteresis
// R11: direction from centre probe at zero crossing
// R12: first pulse is plain speed pulse
// R13: vibration transitions suppress output pulse
// R14: hysteresis suppression always, direction after calibration
// R15: undervoltage detection armed after first switching
// R16: undervoltage forces high current until recovery
// R17: deep supply dip resets and recalibrates
// R18: supply flags and pulse kind codes
`ifndef HSD_DEFS_VH
`define HSD_DEFS_VH
`define HSD_W          12
`define HSD_LIMIT      12'h010
`define HSD_DNC_INIT   12'h020
`define HSD_KIND_NONE  2'h0
`define HSD_KIND_SPEED 2'h1
`define HSD_KIND_FWD   2'h2
`define HSD_KIND_REV   2'h3
`define HSD_OFS_STEP   12'h001
`endif

// ==== hsd_extrema.v ====
// tracks maximum and minimum of the speed samples per period, each between two edges of one kind
`timescale 1ns/1ps
`include "hsd_defs.vh"
module hsd_extrema (
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    sample_valid,
  input  wire signed [11:0]      sample,
  input  wire                    edge_rise,
  input  wire                    edge_fall,
  output reg  signed [11:0]      peak_max,
  output reg  signed [11:0]      peak_min,
  output reg  [1:0]              extrema_count
);
  reg signed [11:0] run_max;
  reg signed [11:0] run_min;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      run_max       <= 12'sh800;
      run_min       <= 12'sh7ff;
      peak_max      <= 12'sh000;
      peak_min      <= 12'sh000;
      extrema_count <= 2'h0;
    end else begin
      if (edge_fall) begin
        peak_max <= run_max;
        run_max  <= sample;
        if (extrema_count != 2'h2) extrema_count <= extrema_count + 2'h1;
      end else if (sample_valid && sample > run_max) begin
        run_max <= sample;
      end
      if (edge_rise) begin
        peak_min <= run_min;
        run_min  <= sample;
        if (extrema_count != 2'h2 && !edge_fall) extrema_count <= extrema_count + 2'h1;
      end else if (sample_valid && sample < run_min) begin
        run_min <= sample;
      end
    end
  end
endmodule // hsd_extrema

// ==== hsd_core.v ====
// digital core: calibration, adaptive hysteresis, direction, vibration, undervoltage
`timescale 1ns/1ps
`include "hsd_defs.vh"
module hsd_core (
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    speed_valid,
  input  wire signed [11:0]      speed_sample,
  input  wire signed [11:0]      centre_probe_signal,
  input  wire                    supply_low,
  input  wire                    supply_reset,
  output reg  signed [11:0]      offset_dac,
  output reg                     pulse_valid,
  output reg  [1:0]              pulse_kind,
  output reg                     high_current,
  output reg                     calibrated,
  output reg  [11:0]             noise_detection_threshold,
  output reg  [11:0]             hysteresis
);
  // supply flags come from the analog side: two-stage sync
  reg low_s1, low_s2, dip_s1, dip_s2;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_s1 <= 1'b0;
      low_s2 <= 1'b0;
      dip_s1 <= 1'b0;
      dip_s2 <= 1'b0;
    end else begin
      low_s1 <= supply_low;
      low_s2 <= low_s1;
      dip_s1 <= supply_reset;
      dip_s2 <= dip_s1;
    end
  end
  wire soft_rst = dip_s2; // see R17 see R18
  // a deep dip also clears the extrema history so calibration restarts
  wire ext_rst = rst | dip_s2; // see R17

  reg signed [11:0] corr;
  reg               state_rising;
  reg               have_state;
  reg               vld;
  reg  [11:0]       amp_pp;
  wire signed [11:0] peak_max;
  wire signed [11:0] peak_min;
  wire [1:0]         extrema_count;
  reg               edge_rise;
  reg               edge_fall;
  reg  [11:0]       amp;
  reg  [11:0]       next_dnc;
  reg  [11:0]       next_hys;
  reg  [11:0]       thr;
  reg  [2:0]        pulse_count;
  reg               uv_armed;
  reg               dir_fwd;
  reg               dir_known;
  reg               prev_dir;
  reg               prev_dir_known;
  reg signed [11:0] ref_level;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      corr <= 12'sh000;
      vld  <= 1'b0;
    end else begin
      corr <= speed_sample - offset_dac; // see R5
      vld  <= speed_valid;
    end
  end

  hsd_extrema u_ext (
    .clock         (clock),
    .rst           (ext_rst),
    .sample_valid  (vld),
    .sample        (corr),
    .edge_rise     (edge_rise),
    .edge_fall     (edge_fall),
    .peak_max      (peak_max),
    .peak_min      (peak_min),
    .extrema_count (extrema_count)
  );

  // amplitude, threshold and hysteresis
  always @* begin
    amp_pp = (peak_max > peak_min) ? peak_max - peak_min : 12'h000;
    // amplitude is half the peak-to-peak swing
    amp = amp_pp >> 1;
    if (!calibrated || extrema_count != 2'h2)
      next_dnc = (amp > (`HSD_LIMIT << 1)) ? amp : (`HSD_LIMIT << 1); // see R2
    else
      next_dnc = ((amp >> 1) > (`HSD_LIMIT << 1)) ? (amp >> 1) : (`HSD_LIMIT << 1); // see R7
    next_hys = ((amp >> 3) > `HSD_LIMIT) ? (amp >> 3) : `HSD_LIMIT; // see R9
    thr = calibrated ? hysteresis : noise_detection_threshold; // see R6
  end

  // slope detection against moving reference; excursions under thr ignored
  always @* begin
    edge_rise = 1'b0;
    edge_fall = 1'b0;
    if (vld) begin
      if ((!have_state || !state_rising) && corr > ref_level + $signed(thr))
        edge_rise = 1'b1; // see R1 see R10 see R14
      else if ((!have_state || state_rising) && corr < ref_level - $signed(thr))
        edge_fall = 1'b1; // see R10
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_rising              <= 1'b0;
      have_state                <= 1'b0;
      ref_level                 <= 12'sh000;
      noise_detection_threshold <= `HSD_DNC_INIT;
      hysteresis                <= `HSD_LIMIT;
      calibrated                <= 1'b0;
      offset_dac                <= 12'sh000;
      pulse_valid               <= 1'b0;
      pulse_kind                <= `HSD_KIND_NONE;
      pulse_count               <= 3'h0;
      uv_armed                  <= 1'b0;
      high_current              <= 1'b0;
      dir_fwd                   <= 1'b0;
      dir_known                 <= 1'b0;
      prev_dir                  <= 1'b0;
      prev_dir_known            <= 1'b0;
    end else if (soft_rst) begin
      state_rising              <= 1'b0;
      have_state                <= 1'b0;
      ref_level                 <= 12'sh000;
      noise_detection_threshold <= `HSD_LIMIT << 1; // see R2 see R17
      calibrated                <= 1'b0;
      offset_dac                <= 12'sh000;
      pulse_valid               <= 1'b0;
      pulse_kind                <= `HSD_KIND_NONE;
      pulse_count               <= 3'h0;
      uv_armed                  <= 1'b0;
      high_current              <= 1'b0;
      dir_known                 <= 1'b0;
      prev_dir_known            <= 1'b0;
    end else begin
      pulse_valid <= 1'b0;
      noise_detection_threshold <= next_dnc;
      hysteresis <= next_hys;
      // track reference at the extreme reached in the current direction
      if (vld) begin
        if (state_rising && corr > ref_level) ref_level <= corr;
        if (!state_rising && corr < ref_level) ref_level <= corr;
      end
      // direction sampled at speed zero crossing
      if (vld && ((corr >= 0) != (ref_level >= 0)) && have_state) begin
        dir_fwd   <= state_rising ? (centre_probe_signal >= 0)
                                  : (centre_probe_signal < 0); // see R11
        dir_known <= 1'b1;
      end
      // offset update, independent of pulse path
      if (extrema_count == 2'h2 && (edge_rise || edge_fall)) begin // see R3 see R4
        // positive steps only on rising edges, negative only on falling
        if (edge_rise && (peak_max + peak_min) > 0) begin
          offset_dac <= offset_dac + $signed(`HSD_OFS_STEP);
          calibrated <= 1'b1; // see R6
        end else if (edge_fall && (peak_max + peak_min) < 0) begin
          offset_dac <= offset_dac - $signed(`HSD_OFS_STEP);
          calibrated <= 1'b1;
        end else if ((peak_max + peak_min) == 0) begin
          calibrated <= 1'b1;
        end
      end
      if (edge_fall) begin
        state_rising <= 1'b0;
        have_state   <= 1'b1;
        ref_level    <= corr;
      end
      if (edge_rise) begin
        state_rising <= 1'b1;
        have_state   <= 1'b1;
        ref_level    <= corr;
        prev_dir       <= dir_fwd;
        prev_dir_known <= dir_known;
        if (calibrated && dir_known && prev_dir_known && dir_fwd != prev_dir) begin
          pulse_kind <= `HSD_KIND_NONE; // see R13 see R14
        end else if (pulse_count == 3'h2 && !calibrated
                     && amp < (`HSD_LIMIT << 1)) begin
          pulse_count <= pulse_count + 3'h1; // see R8
        end else begin
          pulse_valid <= 1'b1;
          if (pulse_count != 3'h7) pulse_count <= pulse_count + 3'h1;
          if (pulse_count == 3'h0 || !calibrated || !dir_known)
            pulse_kind <= `HSD_KIND_SPEED; // see R12 see R8
          else
            pulse_kind <= dir_fwd ? `HSD_KIND_FWD : `HSD_KIND_REV; // see R18
          uv_armed <= 1'b1; // see R15
        end
      end
      high_current <= uv_armed & low_s2; // see R16
    end
  end
endmodule // hsd_core

// ==== hsd_monitor.sv ====
// concurrent checks on the speed and direction core outputs
`timescale 1ns/1ps
`include "hsd_defs.vh"
module hsd_monitor (
  input wire               clock,
  input wire               rst,
  input wire               speed_valid,
  input wire               supply_low,
  input wire               supply_reset,
  input wire signed [11:0] offset_dac,
  input wire               pulse_valid,
  input wire [1:0]         pulse_kind,
  input wire               high_current,
  input wire               calibrated,
  input wire [11:0]        noise_detection_threshold,
  input wire [11:0]        hysteresis
);
  reg armed;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (pulse_valid) begin
      armed <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_uv_rise;
    armed && $rose(supply_low);
  endsequence
  sequence s_pulse_end;
    ##1 !pulse_valid;
  endsequence
  pulse_once_a: assert property (pulse_valid |-> s_pulse_end) else $error("pulse too long");
  first_plain_a: assert property (pulse_valid && !armed |-> pulse_kind == `HSD_KIND_SPEED)
    else $error("first pulse not plain");
  thr_floor_a: assert property (noise_detection_threshold >= 12'h020)
    else $error("noise threshold under floor");
  hyst_floor_a: assert property (hysteresis >= `HSD_LIMIT) else $error("hysteresis under floor");
  uv_arm_a: assert property (!armed |-> !high_current) else $error("undervoltage not armed");
  uv_rise_a: assert property (s_uv_rise |-> ##[1:4] high_current) else $error("no high current");
  uv_hold_a: assert property (high_current && supply_low |=> high_current) else $error("dropped");
  cal_drop_a: assert property ($fell(calibrated) |-> $past(supply_reset, 2) || $past(supply_reset, 3))
    else $error("calibration lost");
  dac_step_a: assert property ($changed(offset_dac) && offset_dac != 12'h000 |->
    offset_dac == $past(offset_dac) + 12'sd1 || offset_dac == $past(offset_dac) - 12'sd1)
    else $error("offset step wrong");
  pulse_cause_a: assert property (pulse_valid |-> $past(speed_valid, 2) || $past(speed_valid, 3))
    else $error("pulse without sample");
endmodule // hsd_monitor
bind hsd_core hsd_monitor u_mon (.clock(clock), .rst(rst), .speed_valid(speed_valid),
  .supply_low(supply_low), .supply_reset(supply_reset), .offset_dac(offset_dac),
  .pulse_valid(pulse_valid), .pulse_kind(pulse_kind), .high_current(high_current),
  .calibrated(calibrated), .noise_detection_threshold(noise_detection_threshold),
  .hysteresis(hysteresis));

// ==== hsd_tcu_model.sv ====
// control unit side: counts received pulses and forward pulses, records first kind
`timescale 1ns/1ps
`include "hsd_defs.vh"
module hsd_tcu_model (
  input  wire       clock,
  input  wire       rst,
  input  wire       pulse_valid,
  input  wire [1:0] pulse_kind,
  output reg  [7:0] pulse_cnt,
  output reg  [7:0] fwd_cnt,
  output reg  [1:0] first_kind
);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_cnt  <= 8'h00;
      fwd_cnt    <= 8'h00;
      first_kind <= `HSD_KIND_NONE;
    end else if (pulse_valid) begin
      pulse_cnt <= pulse_cnt + 8'h01;
      if (pulse_cnt == 8'h00) first_kind <= pulse_kind;
      if (pulse_kind == `HSD_KIND_FWD) fwd_cnt <= fwd_cnt + 8'h01;
    end
  end
endmodule // hsd_tcu_model

// ==== hsd_core_tb.sv ====
// random and directed stimulus for the speed and direction core
`timescale 1ns/1ps
`include "hsd_defs.vh"
module hsd_core_tb;
  reg                clock = 1'b0;
  reg                rst = 1'b1;
  reg                speed_valid = 1'b0;
  reg  signed [11:0] speed_sample = 12'h000;
  reg  signed [11:0] centre_probe_signal = 12'h000;
  reg                supply_low = 1'b0;
  reg                supply_reset = 1'b0;
  wire signed [11:0] offset_dac;
  wire               pulse_valid;
  wire [1:0]         pulse_kind;
  wire               high_current;
  wire               calibrated;
  wire [11:0]        noise_detection_threshold;
  wire [11:0]        hysteresis;
  wire [7:0]         pulse_cnt;
  wire [7:0]         fwd_cnt;
  wire [1:0]         first_kind;
  integer            error_cnt = 0;
  integer            compares = 0;
  integer            i;
  always #5 clock = ~clock;
  hsd_core uut (.clock(clock), .rst(rst), .speed_valid(speed_valid), .speed_sample(speed_sample),
    .centre_probe_signal(centre_probe_signal), .supply_low(supply_low),
    .supply_reset(supply_reset), .offset_dac(offset_dac), .pulse_valid(pulse_valid),
    .pulse_kind(pulse_kind), .high_current(high_current), .calibrated(calibrated),
    .noise_detection_threshold(noise_detection_threshold), .hysteresis(hysteresis));
  hsd_tcu_model tcu (.clock(clock), .rst(rst), .pulse_valid(pulse_valid),
    .pulse_kind(pulse_kind), .pulse_cnt(pulse_cnt), .fwd_cnt(fwd_cnt), .first_kind(first_kind));
  task check(input [11:0] seen, input [11:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // triangle from -amp to amp, period 64 samples, plus dc
  function [11:0] wave(input integer n, input integer amp, input integer dc);
    integer p;
    integer r;
    p = n % 64;
    r = (p < 32) ? (p * amp / 16 - amp) : (3 * amp - p * amp / 16);
    r = r + dc;
    wave = r[11:0];
  endfunction
  task run(input integer n, input integer amp, input integer dc, input integer ph);
    for (i = 0; i < n; i = i + 1) begin
      @(negedge clock);
      speed_valid <= 1'b1;
      speed_sample <= wave(i, amp, dc) + 12'(int'($urandom % 7) - 3);
      centre_probe_signal <= wave(i + ph, amp, 0);
    end
  endtask
  task print_verdict;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial begin
    i = $urandom(32'h2ad38692);
    repeat (8) @(negedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(noise_detection_threshold, 12'h020);
    check(hysteresis, `HSD_LIMIT);
    $display("test reset done");
    run(256, 8, 0, 16);
    check(12'(pulse_cnt), 12'h000);
    $display("test noise done");
    run(1024, 512, 64, 16);
    check(12'(first_kind), 12'(`HSD_KIND_SPEED));
    check(12'(pulse_cnt >= 8'd2), 12'h001);
    check(12'(calibrated), 12'h001);
    check(12'(fwd_cnt > 8'd0), 12'h001);
    check(12'(offset_dac > 12'sd0), 12'h001);
    check(12'(hysteresis > `HSD_LIMIT), 12'h001);
    check(12'(noise_detection_threshold > 12'h020), 12'h001);
    $display("test forward done");
    run(512, 512, 64, 48);
    check(12'(pulse_kind), 12'(`HSD_KIND_REV));
    check(12'(calibrated), 12'h001);
    $display("test reverse done");
    supply_low <= 1'b1;
    repeat (6) @(negedge clock);
    check(12'(high_current), 12'h001);
    supply_low <= 1'b0;
    repeat (6) @(negedge clock);
    check(12'(high_current), 12'h000);
    $display("test undervoltage done");
    speed_valid <= 1'b0;
    supply_reset <= 1'b1;
    repeat (4) @(negedge clock);
    supply_reset <= 1'b0;
    repeat (4) @(negedge clock);
    check(12'(calibrated), 12'h000);
    check(offset_dac, 12'h000);
    $display("test supply reset done");
    print_verdict;
  end
endmodule // hsd_core_tb
